// ---- design/fdc_regs_defines.svh ----
// Offsets, field positions, reset values and timing counts of the host register set.
// Assumes inclusion by bare name from the design and testbench modules.
`ifndef FDC_REGS_DEFINES_SVH
`define FDC_REGS_DEFINES_SVH
`define ADDR_MAIN_STATUS    16'h03F4
`define ADDR_DATA_PORT      16'h03F5
`define ADDR_DIGITAL_INPUT  16'h03F7
`define MS_DRIVE0_SEEKING   0
`define MS_DRIVE1_SEEKING   1
`define MS_CMD_BUSY         4
`define MS_POLLED_MODE      5
`define MS_DIRECTION        6
`define MS_REQUEST          7
`define RATE_250K           2'h2
`define RATE_300K           2'h1
`define RATE_500K           2'h0
`define RATE_1M             2'h3
`define UNDERRUN_FILL       8'h00
`define FIFO_DEPTH          16
`define SERVICE_MARGIN_NS   1500
`define CLK_PERIOD_NS       25
`define SERVICE_MARGIN_CYC  ((`SERVICE_MARGIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WB_ADDR_CMD         4'h0
`define WB_ADDR_STATUS      4'h4
`define WB_ADDR_WDATA       4'h8
`define WB_ADDR_RDATA       4'hC
`endif

// ---- design/fdc_regs_pkg.sv ----
// Types shared by both ends of the host register link.
// Assumes fdc_regs_defines.svh for numeric constants.
package fdc_regs_pkg;
  typedef enum logic [1:0] {
    MODE_BASE,
    MODE_SECOND,
    MODE_THIRD
  } compat_mode_t;
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_COMMAND,
    PH_EXEC,
    PH_DRAIN,
    PH_RESULT
  } phase_t;
  typedef enum logic [1:0] {
    HB_IDLE,
    HB_ISSUE,
    HB_WAIT
  } host_bus_t;
endpackage

// ---- design/fdc_host_if.sv ----
// Parallel 8-bit ISA-style host link between register set and host end.
// Assumes one clock; host and device data run on separate wires, each with its own enable.
`timescale 1ns/100ps
`default_nettype none
interface fdc_host_if (
  input wire logic clk_i
);
  logic [15:0] addr;
  logic        rd;
  logic        wr;
  logic [7:0]  host_data;
  logic        host_data_oe_n;
  logic [7:0]  dev_data;
  logic [7:0]  dev_data_oe_n;
  modport device (
    input  addr,
    input  rd,
    input  wr,
    input  host_data,
    input  host_data_oe_n,
    output dev_data,
    output dev_data_oe_n
  );
  modport host (
    output addr,
    output rd,
    output wr,
    output host_data,
    output host_data_oe_n,
    input  dev_data,
    input  dev_data_oe_n
  );
endinterface
`default_nettype wire

// ---- design/fdc_sync2.sv ----
// Two-flop synchroniser for one pin level.
// Assumes the input may be asynchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module fdc_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic stage1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      stage1  <= pin_i;
      level_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- design/fdc_regs_device.sv ----
// Host-facing register set: status, data port with FIFO, digital input, rate configuration.
// Assumes a core that reports phases and seeks; cable pins arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
`include "fdc_regs_defines.svh"
// How it works
// RL1: Status readable at any time, always valid
// RL2: Seeking flags follow each drive's seek
// RL3: Busy from first byte to result end
// RL4: Polled flag set during polled execution
// RL5: Direction flag tells read versus write
// RL6: Request flag gates every data port access
// RL7: Host reads status before each polled byte
// RL8: Status updated the cycle after transfer
// RL9: One data port carries all bytes
// RL10: FIFO off after reset, configure enables
// RL11: FIFO bypassed for parameters, cleared at execution
// RL12: Overrun or underrun aborts the transfer
// RL13: Underrun write pads sector with zeros
// RL14: Host drains reads after overrun
// RL15: Host services FIFO within threshold window
// RL16: Base mode drives only input bit 7
// RL17: Bit 7 is inverted or forced change
// RL18: Second mode shows density and rate
// RL19: Third mode shows rate, precomp, gate
// RL20: Rate kept by soft reset, 250K hard
// RL21: Rate configuration sets rate and precomp; the code sets precomp in third mode only
// RL22: Density pin high on hard reset only
// RL23: Latest rate write of either wins
module fdc_regs_device #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  fdc_host_if.device                     bus,
  input  wire logic                      soft_reset_i,
  input  wire fdc_regs_pkg::compat_mode_t mode_i,
  input  wire logic                      media_changed_pin_n_i,
  input  wire logic                      force_change_en_i,
  input  wire logic                      force_change_val_i,
  input  wire logic                      dma_gate_enable_i,
  input  wire logic                      rate_select_wr_i,
  input  wire logic [1:0]                rate_select_val_i,
  input  wire logic                      seek0_i,
  input  wire logic                      seek1_i,
  input  wire fdc_regs_pkg::phase_t      phase_i,
  input  wire logic                      read_dir_i,
  input  wire logic                      polled_sel_i,
  input  wire logic                      fifo_enable_i,
  input  wire logic [3:0]                fifo_threshold_i,
  input  wire logic                      disk_take_i,
  input  wire logic                      disk_give_i,
  input  wire logic [7:0]                disk_byte_i,
  output logic [7:0]                     disk_byte_o,
  output logic                           disk_byte_valid_o,
  output logic                           xfer_error_o,
  output logic [1:0]                     rate_select_o,
  output logic                           density_select_pin_o
);
  localparam int AW = $clog2(FIFO_DEPTH);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [AW:0]                count;
    logic [1:0]                 rate;
    logic                       precomp;
    logic                       fifo_on;
    logic                       error;
    logic [7:0]                 dout;
    logic [7:0]                 oe_n;
    logic [7:0]                 disk_out;
    logic                       disk_valid;
    logic                       density;
    logic                       rd_q;
    logic                       wr_q;
  } dev_state_t;
  dev_state_t st;
  dev_state_t next_st;
  logic       change_sync;
  logic       rd_edge;
  logic       wr_edge;
  logic       change_bit;
  logic       request;
  logic [7:0] status;
  logic [AW:0] limit;
  fdc_sync2 u_change (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (media_changed_pin_n_i),
    .level_o (change_sync)
  );
  // ****************************************
  // Status composition
  // ****************************************
  always_comb begin
    rd_edge    = bus.rd & ~st.rd_q;
    wr_edge    = bus.wr & ~st.wr_q;
    change_bit = force_change_en_i ? force_change_val_i : ~change_sync; // RL17
    limit      = st.fifo_on ? (AW+1)'(fifo_threshold_i) + (AW+1)'(1) : (AW+1)'(1);
    unique case (phase_i)
      fdc_regs_pkg::PH_COMMAND, fdc_regs_pkg::PH_IDLE: request = 1'b1;
      fdc_regs_pkg::PH_RESULT: request = 1'b1;
      fdc_regs_pkg::PH_DRAIN:  request = st.count != '0; // RL14
      fdc_regs_pkg::PH_EXEC:   request = read_dir_i ? (st.count != '0) : (st.count < limit);
      default:                 request = 1'b0;
    endcase
    status = 8'h00;
    status[`MS_DRIVE0_SEEKING] = seek0_i; // RL2
    status[`MS_DRIVE1_SEEKING] = seek1_i; // RL2
    status[`MS_CMD_BUSY]       = phase_i != fdc_regs_pkg::PH_IDLE; // RL3
    status[`MS_POLLED_MODE]    = polled_sel_i & (phase_i == fdc_regs_pkg::PH_EXEC); // RL4
    status[`MS_DIRECTION]      = request & (read_dir_i | (phase_i == fdc_regs_pkg::PH_RESULT)); // RL5
    // An error stops execution transfers only; drain and result reads stay open
    status[`MS_REQUEST]        = request & ~(st.error & (phase_i == fdc_regs_pkg::PH_EXEC)); // RL6 RL14
  end
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st            = st;
    next_st.rd_q       = bus.rd;
    next_st.wr_q       = bus.wr;
    next_st.disk_valid = 1'b0;
    next_st.oe_n       = 8'hFF;
    if (soft_reset_i) begin
      next_st.fifo_on = 1'b0; // RL10
      next_st.count   = '0;
      next_st.error   = 1'b0;
    end
    // Configure in the reset cycle still wins
    if (fifo_enable_i) begin
      next_st.fifo_on = 1'b1; // RL10
    end
    if (phase_i != fdc_regs_pkg::PH_EXEC && phase_i != fdc_regs_pkg::PH_DRAIN) begin
      next_st.count = '0; // RL11
    end
    if (phase_i == fdc_regs_pkg::PH_IDLE) begin
      next_st.error = 1'b0;
    end
    if (rate_select_wr_i) begin
      next_st.rate = rate_select_val_i; // RL23
    end
    if (bus.rd) begin
      if (bus.addr == `ADDR_MAIN_STATUS) begin
        next_st.dout = status; // RL1 RL8
        next_st.oe_n = 8'h00;
      end else if (bus.addr == `ADDR_DATA_PORT) begin
        // Latched at the strobe edge; the pop shifts the head meanwhile
        if (rd_edge) begin
          next_st.dout = st.mem[0]; // RL9
        end
        next_st.oe_n = 8'h00;
      end else if (bus.addr == `ADDR_DIGITAL_INPUT) begin
        next_st.dout[7] = change_bit;
        unique case (mode_i)
          fdc_regs_pkg::MODE_BASE: begin
            next_st.oe_n = 8'h7F; // RL16
          end
          fdc_regs_pkg::MODE_SECOND: begin
            next_st.dout[6:3] = 4'hF; // RL18
            next_st.dout[2:1] = st.rate;
            next_st.dout[0]   = ~(st.rate == `RATE_500K || st.rate == `RATE_1M);
            next_st.oe_n      = 8'h00;
          end
          default: begin
            next_st.dout[6:4] = 3'h0; // RL19
            next_st.dout[3]   = dma_gate_enable_i;
            next_st.dout[2]   = st.precomp;
            next_st.dout[1:0] = st.rate;
            next_st.oe_n      = 8'h00;
          end
        endcase
      end
    end
    // Data port pops and pushes; command bytes bypass the FIFO
    if (rd_edge && bus.addr == `ADDR_DATA_PORT && request && st.count != '0) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        next_st.mem[i] = st.mem[i+1];
      end
      next_st.count = st.count - (AW+1)'(1);
    end
    if (wr_edge && bus.addr == `ADDR_DIGITAL_INPUT) begin
      next_st.rate = bus.host_data[1:0]; // RL21 RL23
      if (mode_i == fdc_regs_pkg::MODE_THIRD) begin
        next_st.precomp = bus.host_data[2]; // RL21
      end
    end
    if (wr_edge && bus.addr == `ADDR_DATA_PORT && request) begin
      if (phase_i == fdc_regs_pkg::PH_EXEC && !read_dir_i) begin
        next_st.mem[st.count[AW-1:0]] = bus.host_data;
        next_st.count = st.count + (AW+1)'(1);
      end else begin
        next_st.disk_out   = bus.host_data; // RL9 RL11
        next_st.disk_valid = 1'b1;
      end
    end
    if (phase_i == fdc_regs_pkg::PH_EXEC && read_dir_i && disk_give_i) begin
      if (st.count >= limit) begin
        next_st.error = 1'b1; // RL12
      end else if (!st.error) begin
        next_st.mem[st.count[AW-1:0]] = disk_byte_i;
        next_st.count = st.count + (AW+1)'(1);
      end
    end
    if (phase_i == fdc_regs_pkg::PH_EXEC && !read_dir_i && disk_take_i) begin
      if (st.count == '0 || st.error) begin
        next_st.error      = 1'b1; // RL12
        next_st.disk_out   = `UNDERRUN_FILL; // RL13
        next_st.disk_valid = 1'b1;
      end else begin
        next_st.disk_out   = st.mem[0];
        next_st.disk_valid = 1'b1;
        for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
          next_st.mem[i] = st.mem[i+1];
        end
        next_st.count = st.count - (AW+1)'(1);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= '0;
      st.rate    <= `RATE_250K; // RL20
      st.oe_n    <= 8'hFF;
      st.density <= 1'b1; // RL22
    end else begin
      st <= next_st;
    end
  end
  assign bus.dev_data          = st.dout;
  assign bus.dev_data_oe_n     = st.oe_n;
  assign disk_byte_o           = st.disk_out;
  assign disk_byte_valid_o     = st.disk_valid;
  assign xfer_error_o          = st.error;
  assign rate_select_o         = st.rate;
  assign density_select_pin_o  = st.density;
endmodule
`default_nettype wire

// ---- design/fdc_regs_host.sv ----
// Host end: takes orders over classic Wishbone, runs one ISA cycle on the link.
// Assumes the device answers reads one cycle after the strobe rises.
`timescale 1ns/100ps
`default_nettype none
`include "fdc_regs_defines.svh"
module fdc_regs_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  fdc_host_if.host         bus
);
  typedef struct packed {
    fdc_regs_pkg::host_bus_t state;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        is_write;
    logic [7:0]  rdata;
    logic        busy;
    logic        rd;
    logic        wr;
    logic        drive_n;
    logic [1:0]  cnt;
    logic        ack;
    logic [31:0] dat;
  } host_state_t;
  host_state_t st;
  host_state_t next_st;
  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    unique case (st.state)
      fdc_regs_pkg::HB_IDLE: begin
        if (wb_cyc_i && wb_stb_i && !st.ack) begin
          next_st.ack = 1'b1;
          next_st.dat = 32'h0000_0000;
          unique case (wb_adr_i)
            `WB_ADDR_CMD: begin
              if (wb_we_i && wb_sel_i[0] && !st.busy) begin
                next_st.addr     = wb_dat_i[15:0];
                next_st.is_write = wb_dat_i[16];
                next_st.busy     = 1'b1;
                next_st.state    = fdc_regs_pkg::HB_ISSUE;
              end
            end
            `WB_ADDR_STATUS: next_st.dat = {31'h0000_0000, st.busy};
            `WB_ADDR_WDATA: begin
              if (wb_we_i && wb_sel_i[0]) begin
                next_st.wdata = wb_dat_i[7:0];
              end
            end
            `WB_ADDR_RDATA: next_st.dat = {24'h00_0000, st.rdata};
            default: next_st.dat = 32'h0000_0000;
          endcase
        end
      end
      fdc_regs_pkg::HB_ISSUE: begin
        // Polled transfers read status first; software sequences that
        next_st.rd      = ~st.is_write; // RL7
        next_st.wr      = st.is_write; // RL6 RL21
        next_st.drive_n = ~st.is_write;
        next_st.cnt     = 2'h2;
        next_st.state   = fdc_regs_pkg::HB_WAIT;
      end
      default: begin
        next_st.cnt = st.cnt - 2'h1;
        if (st.cnt == 2'h0) begin
          next_st.rdata   = bus.dev_data; // RL9
          next_st.rd      = 1'b0;
          next_st.wr      = 1'b0;
          next_st.drive_n = 1'b1;
          next_st.busy    = 1'b0;
          next_st.state   = fdc_regs_pkg::HB_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= '0;
      st.state   <= fdc_regs_pkg::HB_IDLE;
      st.drive_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  assign wb_ack_o           = st.ack;
  assign wb_dat_o           = st.dat;
  assign bus.addr           = st.addr;
  assign bus.rd             = st.rd;
  assign bus.wr             = st.wr;
  assign bus.host_data      = st.wdata;
  assign bus.host_data_oe_n = st.drive_n;
endmodule
`default_nettype wire

// ---- testbench/fdc_regs_properties.sv ----
// Checker of the link between the register set and the host end.
// Assumes tb_top instantiates it beside the link interface.
`timescale 1ns/100ps
`default_nettype none
`include "fdc_regs_defines.svh"
module fdc_regs_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] addr,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic [7:0]  host_data,
  input wire logic        host_data_oe_n,
  input wire logic [7:0]  dev_data,
  input wire logic [7:0]  dev_data_oe_n
);
  // ********
  // Link properties
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic mapped;
  assign mapped = addr == `ADDR_MAIN_STATUS || addr == `ADDR_DATA_PORT || addr == `ADDR_DIGITAL_INPUT;
  status_drive_a: assert property ($rose(rd) && addr == `ADDR_MAIN_STATUS |=> dev_data_oe_n == 8'h00)
    else $error("status read not driven");
  change_bit_a: assert property ($rose(rd) && addr == `ADDR_DIGITAL_INPUT |=> !dev_data_oe_n[7])
    else $error("input bit 7 not driven");
  unmapped_quiet_a: assert property (rd && !mapped |-> dev_data_oe_n == 8'hFF)
    else $error("unmapped read driven");
  bus_release_a: assert property ($fell(rd) |-> ##[0:1] dev_data_oe_n == 8'hFF)
    else $error("data bus not released");
  idle_quiet_a: assert property (!rd && !$past(rd) |-> dev_data_oe_n == 8'hFF)
    else $error("device drives while idle");
  answer_hold_a: assert property (rd && $past(rd) && $past(rd, 2) |-> $stable(dev_data_oe_n))
    else $error("read answer not held");
  data_hold_a: assert property (rd && $past(rd) && $past(rd, 2) && addr == `ADDR_DATA_PORT |-> $stable(dev_data))
    else $error("data port byte not held");
  rd_length_a: assert property ($rose(rd) |-> rd [*3] ##1 !rd)
    else $error("read strobe length wrong");
  wr_length_a: assert property ($rose(wr) |-> wr [*3] ##1 !wr)
    else $error("write strobe length wrong");
  one_dir_a: assert property (!(rd && wr))
    else $error("read and write together");
  host_drive_a: assert property (wr && $past(wr) |-> !host_data_oe_n && $stable(host_data))
    else $error("host write data not held");
  host_quiet_a: assert property (rd |-> host_data_oe_n)
    else $error("host drives during read");
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Bench joining both ends over the link; Wishbone tasks drive the host end.
// Assumes design files and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "fdc_regs_defines.svh"
module tb_top;
  // ********
  // Signals
  // ********
  logic                       clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic [4:0]                 pls = 5'h00;
  fdc_regs_pkg::compat_mode_t mode = fdc_regs_pkg::MODE_BASE;
  fdc_regs_pkg::phase_t       phase = fdc_regs_pkg::PH_IDLE;
  logic                       chg_n = 1'b1;
  logic                       frc_en = 1'b0;
  logic                       frc_val = 1'b0;
  logic                       gate = 1'b0;
  logic [1:0]                 rs_val = 2'h0;
  logic                       seek0 = 1'b0;
  logic                       seek1 = 1'b0;
  logic                       rdir = 1'b0;
  logic                       polled = 1'b0;
  logic [3:0]                 fifo_thr = 4'h0;
  logic [7:0]                 dbyte = 8'h00;
  logic [3:0]                 wb_adr = 4'h0;
  logic [31:0]                wb_wdat = 32'h0;
  logic                       wb_we = 1'b0;
  logic                       wb_req = 1'b0;
  logic [31:0]                wb_rdat;
  logic                       wb_ack;
  logic [7:0]                 disk_byte, last_disk, last_oe, s, d;
  logic                       disk_vld, xerr, dens;
  logic [1:0]                 rate;
  int                         miscompares = 0;
  int                         samples_checked = 0;
  always #12.5 clk_i = ~clk_i;
  fdc_host_if link (.clk_i(clk_i));
  fdc_regs_device #(.FIFO_DEPTH(`FIFO_DEPTH)) fdc_regs_device_inst (
    .clk_i(clk_i), .rst_i(rst_i), .bus(link), .soft_reset_i(pls[2]), .mode_i(mode),
    .media_changed_pin_n_i(chg_n), .force_change_en_i(frc_en), .force_change_val_i(frc_val),
    .dma_gate_enable_i(gate), .rate_select_wr_i(pls[4]), .rate_select_val_i(rs_val),
    .seek0_i(seek0), .seek1_i(seek1), .phase_i(phase), .read_dir_i(rdir), .polled_sel_i(polled),
    .fifo_enable_i(pls[3]), .fifo_threshold_i(fifo_thr), .disk_take_i(pls[1]), .disk_give_i(pls[0]),
    .disk_byte_i(dbyte), .disk_byte_o(disk_byte), .disk_byte_valid_o(disk_vld), .xfer_error_o(xerr),
    .rate_select_o(rate), .density_select_pin_o(dens));
  fdc_regs_host fdc_regs_host_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_we_i(wb_we),
    .wb_sel_i(4'hF), .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .bus(link));
  fdc_regs_properties fdc_regs_properties_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr(link.addr), .rd(link.rd), .wr(link.wr),
    .host_data(link.host_data), .host_data_oe_n(link.host_data_oe_n),
    .dev_data(link.dev_data), .dev_data_oe_n(link.dev_data_oe_n));
  always @(posedge clk_i) begin
    if (disk_vld) last_disk <= disk_byte;
    if (link.rd) last_oe <= link.dev_data_oe_n;
  end
  // ********
  // Tasks
  // ********
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic we, input logic [31:0] w, output logic [31:0] r);
    @(posedge clk_i);
    wb_adr <= a;
    wb_we <= we;
    wb_wdat <= w;
    wb_req <= 1'b1;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    r = wb_rdat;
    wb_req <= 1'b0;
  endtask
  // One link cycle; a hang on busy is left to the watchdog
  task automatic io(input logic [15:0] a, input logic is_wr, input logic [7:0] w, output logic [7:0] r);
    logic [31:0] t;
    wb(`WB_ADDR_WDATA, 1'b1, {24'h0, w}, t);
    wb(`WB_ADDR_CMD, 1'b1, {15'h0, is_wr, a}, t);
    do begin
      wb(`WB_ADDR_STATUS, 1'b0, 32'h0, t);
    end while (t[0] !== 1'b0);
    wb(`WB_ADDR_RDATA, 1'b0, 32'h0, t);
    r = t[7:0];
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_i);
    pls <= m;
    @(posedge clk_i);
    pls <= 5'h00;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic hard_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    stop_test();
  end
  initial begin
    hard_reset();
    @(posedge clk_i);
    seek0 <= 1'b1;
    io(`ADDR_MAIN_STATUS, 1'b0, 8'h00, s);
    chk("idle_status", s & 8'h33, 8'h01);
    io(16'h03F0, 1'b0, 8'h00, d);
    @(posedge clk_i);
    seek0 <= 1'b0;
    seek1 <= 1'b1;
    phase <= fdc_regs_pkg::PH_COMMAND;
    io(`ADDR_MAIN_STATUS, 1'b0, 8'h00, s);
    chk("cmd_status", s & 8'hF3, 8'h92);
    io(`ADDR_DATA_PORT, 1'b1, 8'h3C, d);
    chk("cmd_byte", last_disk, 8'h3C);
    @(posedge clk_i);
    seek1 <= 1'b0;
    phase <= fdc_regs_pkg::PH_EXEC;
    rdir <= 1'b1;
    polled <= 1'b1;
    dbyte <= 8'hA5;
    pulse(5'h01);
    io(`ADDR_MAIN_STATUS, 1'b0, 8'h00, s);
    chk("exec_status", s & 8'hF3, 8'hF0);
    io(`ADDR_DATA_PORT, 1'b0, 8'h00, d);
    chk("exec_byte", d, 8'hA5);
    io(`ADDR_MAIN_STATUS, 1'b0, 8'h00, s);
    chk("drained_status", s & 8'h80, 8'h00);
    @(posedge clk_i);
    rdir <= 1'b0;
    polled <= 1'b0;
    io(`ADDR_DATA_PORT, 1'b1, 8'h5C, d);
    pulse(5'h02);
    chk("disk_write", last_disk, 8'h5C);
    pulse(5'h02);
    chk("underrun_fill", last_disk, `UNDERRUN_FILL);
    chk("underrun_err", {7'h0, xerr}, 8'h01);
    hard_reset();
    chk("err_clear", {7'h0, xerr}, 8'h00);
    @(posedge clk_i);
    rdir <= 1'b1;
    pulse(5'h01);
    pulse(5'h01);
    chk("overrun_err", {7'h0, xerr}, 8'h01);
    @(posedge clk_i);
    phase <= fdc_regs_pkg::PH_DRAIN;
    io(`ADDR_MAIN_STATUS, 1'b0, 8'h00, s);
    chk("drain_status", s & 8'hC0, 8'hC0);
    io(`ADDR_DATA_PORT, 1'b0, 8'h00, d);
    chk("drain_byte", d, 8'hA5);
    io(`ADDR_MAIN_STATUS, 1'b0, 8'h00, s);
    chk("drain_empty", s & 8'h80, 8'h00);
    @(posedge clk_i);
    phase <= fdc_regs_pkg::PH_RESULT;
    io(`ADDR_MAIN_STATUS, 1'b0, 8'h00, s);
    chk("result_status", s & 8'hF0, 8'hD0);
    hard_reset();
    // Threshold 3 gives a fill limit of four bytes
    @(posedge clk_i);
    fifo_thr <= 4'h3;
    phase <= fdc_regs_pkg::PH_COMMAND;
    pulse(5'h08);
    phase <= fdc_regs_pkg::PH_EXEC;
    for (int i = 0; i < 4; i++) begin
      dbyte <= 8'h10 + 8'(i);
      pulse(5'h01);
    end
    chk("fifo_no_err", {7'h0, xerr}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      io(`ADDR_DATA_PORT, 1'b0, 8'h00, d);
      chk("fifo_byte", d, 8'h10 + 8'(i));
    end
    @(posedge clk_i);
    phase <= fdc_regs_pkg::PH_IDLE;
    mode <= fdc_regs_pkg::MODE_SECOND;
    for (int r = 0; r < 4; r++) begin
      io(`ADDR_DIGITAL_INPUT, 1'b1, {6'h0, 2'(r)}, d);
      io(`ADDR_DIGITAL_INPUT, 1'b0, 8'h00, d);
      chk("dir_second", d, {1'b0, 4'hF, 2'(r), 1'(r == 1 || r == 2)});
      chk("rate_out", {6'h0, rate}, {6'h0, 2'(r)});
    end
    @(posedge clk_i);
    mode <= fdc_regs_pkg::MODE_THIRD;
    gate <= 1'b1;
    chg_n <= 1'b0;
    rs_val <= 2'h3;
    io(`ADDR_DIGITAL_INPUT, 1'b1, 8'h05, d);
    io(`ADDR_DIGITAL_INPUT, 1'b0, 8'h00, d);
    chk("dir_third", d, 8'h8D);
    pulse(5'h10);
    chk("rate_latest", {6'h0, rate}, 8'h03);
    pulse(5'h04);
    chk("rate_soft", {6'h0, rate}, 8'h03);
    chk("dens_soft", {7'h0, dens}, 8'h01);
    io(`ADDR_DIGITAL_INPUT, 1'b0, 8'h00, d);
    chk("precomp_kept", d, 8'h8F);
    @(posedge clk_i);
    mode <= fdc_regs_pkg::MODE_BASE;
    chg_n <= 1'b1;
    frc_en <= 1'b1;
    frc_val <= 1'b1;
    io(`ADDR_DIGITAL_INPUT, 1'b0, 8'h00, d);
    chk("dir_base", d & 8'h80, 8'h80);
    chk("base_undriven", last_oe, 8'h7F);
    hard_reset();
    chk("rate_hard", {6'h0, rate}, {6'h0, `RATE_250K});
    chk("dens_hard", {7'h0, dens}, 8'h01);
    stop_test();
  end
endmodule
`default_nettype wire
